// ===== test/tb_top.sv
// Self-checking bench for the core state block, driving AHB-Lite.
// Assumes ccr_pkg, ccr_core and ccr_regs.svh on the compile path.
`timescale 1ns/10ps
`default_nettype none
`include "ccr_regs.svh"
module tb_top;
   import ccr_pkg::*;
   logic clk, rst_n, hsel, hwrite, hready, hresp, hreadyout, busy;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] instruction_pointer;
   int fails, tests_run;
   assign hready = hreadyout;
   ccr_core #(.ROM_BYTES(12288), .VEC_BYTES(128)) dut (.clk(clk),
      .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .instruction_pointer(instruction_pointer), .busy(busy));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         fails++;
         finish_test();
      end
   endtask
   // One single word transfer, read data taken at the data-phase edge
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdm(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         bus(1'b0, `CCR_A_STAT, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 50);
      if (rd[0] !== 1'b0) begin
         fails++;
         finish_test();
      end
   endtask
   task automatic cmd(input ccr_op_e op, input logic [7:0] a8,
         input logic [15:0] a16);
      wr(`CCR_A_CMD, {a16, a8, 4'h0, op});
      wait_idle();
   endtask
   task automatic mw(input logic [15:0] a, input logic [7:0] d);
      wr(`CCR_A_MADDR, {16'h0, a});
      wr(`CCR_A_MDATA, {24'h0, d});
   endtask
   task automatic mr(input logic [15:0] a, input logic [7:0] e);
      wr(`CCR_A_MADDR, {16'h0, a});
      rdm(`CCR_A_MDATA, 32'hff, {24'h0, e});
   endtask
   task automatic chk_ip(input logic [15:0] e);
      chk({16'h0, instruction_pointer}, {16'h0, e});
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk({31'h0, busy}, 32'h1);
      rst_n <= 1'b1;
      @(posedge clk);
      wait_idle();
      chk({31'h0, busy}, 32'h0);
   endtask
   task automatic t_reset();
      rdm(`CCR_A_PSW, 32'hff, 32'h02);
      wr(`CCR_UNMAPPED, 32'h5a5a5a5a);
      rdm(`CCR_UNMAPPED, 32'hffffffff, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      $display("Test reset done");
   endtask
   task automatic t_vector();
      wr(`CCR_A_PSW, 32'h81);
      mw(16'h0000, 8'h34);
      mw(16'h0001, 8'h12);
      cmd(OP_RESET, 8'h00, 16'h0);
      chk_ip(16'h1234);
      rdm(`CCR_A_PSW, 32'hff, 32'h02);
      $display("Test vector done");
   endtask
   task automatic t_map();
      logic [15:0] ad [12] = '{16'h0000, 16'h2fff, 16'h3000, 16'hf9ff,
         16'hfa00, 16'hfa1b, 16'hfa1c, 16'hfcff, 16'hfd00, 16'hfeff,
         16'hff00, 16'hffff};
      logic [2:0] rg [12] = '{3'd1, 3'd1, 3'd0, 3'd0, 3'd3, 3'd3, 3'd0,
         3'd0, 3'd2, 3'd2, 3'd4, 3'd4};
      for (int i = 0; i < 12; i++) begin
         wr(`CCR_A_MADDR, {16'h0, ad[i]});
         rdm(`CCR_A_STAT, 32'h1c, {27'h0, rg[i], 2'b00});
      end
      mw(16'hfa05, 8'ha5);
      mw(16'hfe80, 8'h5a);
      mw(16'hfd80, 8'hc3);
      mr(16'hfa05, 8'ha5);
      mr(16'hfe80, 8'h5a);
      mr(16'hfd80, 8'hc3);
      mr(16'hff00, 8'hff);
      $display("Test map done");
   endtask
   task automatic t_pointer();
      cmd(OP_JMP, 8'h00, 16'hbeef);
      chk_ip(16'hbeef);
      cmd(OP_STEP, 8'h03, 16'h0);
      chk_ip(16'hbef2);
      cmd(OP_JMP, 8'h00, 16'hffff);
      cmd(OP_STEP, 8'h01, 16'h0);
      chk_ip(16'h0000);
      wr(`CCR_A_GLO, 32'h44332211);
      wr(`CCR_A_GHI, 32'h88776655);
      cmd(OP_JREG, 8'h03, 16'h0);
      chk_ip(16'h8877);
      cmd(OP_JREG, 8'h00, 16'h0);
      cmd(OP_STEP, 8'h07, 16'h0);
      chk_ip(16'h2218);
      rdm(`CCR_A_GHI, 32'hffffffff, 32'h88776655);
      $display("Test pointer done");
   endtask
   task automatic t_alu();
      wr(`CCR_A_GLO, 32'h00000f00);
      cmd(OP_ADD, 8'h01, 16'h0);
      rdm(`CCR_A_GLO, 32'hff00, 32'h1000);
      rdm(`CCR_A_PSW, 32'h51, 32'h10);
      cmd(OP_ADD, 8'hf0, 16'h0);
      rdm(`CCR_A_PSW, 32'h51, 32'h41);
      cmd(OP_SUB, 8'h01, 16'h0);
      rdm(`CCR_A_GLO, 32'hff00, 32'hff00);
      rdm(`CCR_A_PSW, 32'h51, 32'h11);
      wr(`CCR_A_GLO, 32'h00000200);
      cmd(OP_ROR, 8'h00, 16'h0);
      rdm(`CCR_A_GLO, 32'hff00, 32'h8100);
      rdm(`CCR_A_PSW, 32'h01, 32'h00);
      cmd(OP_BIT, 8'h07, 16'h0);
      rdm(`CCR_A_PSW, 32'h01, 32'h01);
      cmd(OP_BIT, 8'h01, 16'h0);
      rdm(`CCR_A_PSW, 32'h01, 32'h00);
      $display("Test flags done");
   endtask
   task automatic t_stack();
      wr(`CCR_A_PSW, 32'h53);
      wr(`CCR_A_SP, 32'h0000fd10);
      cmd(OP_SAVE, 8'h00, 16'h0);
      rdm(`CCR_A_SP, 32'hffff, 32'hfd0f);
      mr(16'hfd0f, 8'h53);
      wr(`CCR_A_PSW, 32'h02);
      cmd(OP_RESTORE, 8'h00, 16'h0);
      rdm(`CCR_A_PSW, 32'hff, 32'h53);
      rdm(`CCR_A_SP, 32'hffff, 32'hfd10);
      $display("Test stack done");
   endtask
   task automatic t_int();
      mw(16'h0006, 8'h00);
      mw(16'h0007, 8'h30);
      mw(16'h0004, 8'h00);
      mw(16'h0005, 8'h40);
      wr(`CCR_A_SP, 32'h0000fd20);
      wr(`CCR_A_PSW, 32'h02);
      wr(`CCR_A_MASK, 32'hfffffffb);
      cmd(OP_JMP, 8'h00, 16'h1234);
      cmd(OP_EI, 8'h00, 16'h0);
      rdm(`CCR_A_PSW, 32'h80, 32'h80);
      cmd(OP_INT, 8'h02, 16'h0);
      chk_ip(16'h3000);
      rdm(`CCR_A_PSW, 32'h80, 32'h00);
      rdm(`CCR_A_SP, 32'hffff, 32'hfd1d);
      mr(16'hfd1f, 8'h82);
      mr(16'hfd1e, 8'h12);
      mr(16'hfd1d, 8'h34);
      cmd(OP_INT, 8'h02, 16'h0);
      chk_ip(16'h3000);
      cmd(OP_INT, 8'h01, 16'h0);
      chk_ip(16'h4000);
      cmd(OP_EI, 8'h00, 16'h0);
      wr(`CCR_A_MASK, 32'hffffffff);
      cmd(OP_INT, 8'h02, 16'h0);
      chk_ip(16'h4000);
      cmd(OP_INTERRUPT_RETURN_INSTRUCTION, 8'h00, 16'h0);
      chk_ip(16'h3000);
      rdm(`CCR_A_PSW, 32'h80, 32'h00);
      rdm(`CCR_A_SP, 32'hffff, 32'hfd1d);
      cmd(OP_EI, 8'h00, 16'h0);
      cmd(OP_DI, 8'h00, 16'h0);
      rdm(`CCR_A_PSW, 32'h80, 32'h00);
      wr(`CCR_A_MASK, 32'h00000000);
      cmd(OP_EI, 8'h00, 16'h0);
      cmd(OP_INT, 8'h11, 16'h0);
      chk_ip(16'h3000);
      rdm(`CCR_A_SP, 32'hffff, 32'hfd1d);
      $display("Test interrupt done");
   endtask
   task automatic t_table_call_instruction();
      mw(16'h0046, 8'h78);
      mw(16'h0047, 8'h56);
      mw(16'h007e, 8'hcd);
      mw(16'h007f, 8'hab);
      cmd(OP_TABLE_CALL_INSTRUCTION, 8'h03, 16'h0);
      chk_ip(16'h5678);
      cmd(OP_TABLE_CALL_INSTRUCTION, 8'h1f, 16'h0);
      chk_ip(16'habcd);
      $display("Test table call done");
   endtask
   task automatic t_reset2();
      wr(`CCR_A_PSW, 32'h53);
      do_reset();
      rdm(`CCR_A_PSW, 32'hff, 32'h02);
      $display("Test second reset done");
   endtask
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      fails = 0;
      tests_run = 0;
      do_reset();
      t_reset();
      t_vector();
      t_map();
      t_pointer();
      t_alu();
      t_stack();
      t_int();
      t_table_call_instruction();
      t_reset2();
      finish_test();
   end
endmodule
`default_nettype wire

// ===== verilog/ccr_core.sv
// Core state: pointer, flags, stack, byte registers and memory map.
// Assumes one AHB-Lite master and a single clock domain.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ccr_regs.svh"
module ccr_core #(
   parameter int ROM_BYTES = `CCR_ROM_BYTES,
   parameter int VEC_BYTES = `CCR_VEC_BYTES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [15:0] instruction_pointer,
   output logic busy
);
   import ccr_pkg::*;
   localparam int VA = $clog2(VEC_BYTES);
   ccr_state_e st, next_st;
   logic [7:0] processor_flags_byte;
   logic [15:0] stack_top_pointer;
   logic [7:0] gpr [8];
   logic [31:0] mask;
   logic [15:0] maddr, vaddr;
   logic [1:0] cnt;
   logic vec_go, dp_wr;
   logic [7:0] dp_a;
   logic [7:0] hram [512];
   logic [7:0] dram [`CCR_DRAM_N];
   logic [7:0] vrom [VEC_BYTES];

   // Address map decode
   function automatic ccr_region_e region(input logic [15:0] a);
      if (a >= `CCR_HRAM_LO && a <= `CCR_HRAM_HI)
         return RG_HRAM;
      if (a >= `CCR_DRAM_LO && a <= `CCR_DRAM_HI)
         return RG_DRAM;
      if (a >= `CCR_SFR_LO)
         return RG_SFR;
      if (32'(a) < ROM_BYTES)
         return RG_PROG;
      return RG_NONE;
   endfunction

   // One byte of the unified 64 KB space
   function automatic logic [7:0] rd(input logic [15:0] a);
      case (region(a))
         RG_PROG: rd = (32'(a) < VEC_BYTES) ? vrom[a[VA-1:0]] : 8'h00;
         RG_HRAM: rd = hram[a[8:0]];
         RG_DRAM: rd = dram[a[4:0]];
         default: rd = `CCR_UNMAPPED;
      endcase
   endfunction

   // Bus decode
   wire take = hsel && htrans[1] && hready;
   wire idle = st == ST_IDLE;
   wire w_cmd = dp_wr && dp_a == `CCR_A_CMD;
   wire w_pc = dp_wr && dp_a == `CCR_A_PC && idle;
   wire w_psw = dp_wr && dp_a == `CCR_A_PSW && idle;
   wire w_sp = dp_wr && dp_a == `CCR_A_SP && idle;
   wire w_glo = dp_wr && dp_a == `CCR_A_GLO && idle;
   wire w_ghi = dp_wr && dp_a == `CCR_A_GHI && idle;
   wire w_mask = dp_wr && dp_a == `CCR_A_MASK;
   wire w_maddr = dp_wr && dp_a == `CCR_A_MADDR;
   wire w_mdata = dp_wr && dp_a == `CCR_A_MDATA && idle;

   // Command fields
   wire [3:0] op = hwdata[3:0];
   wire [7:0] a8 = hwdata[15:8];
   wire [15:0] a16 = hwdata[31:16];
   wire go = w_cmd && idle;
   wire [4:0] src = a8[4:0];
   wire nmi = src == `CCR_NMI_SRC;
   wire ie = processor_flags_byte[`CCR_F_IE];
   wire [15:0] vec_a = `CCR_VEC_BASE + 16'({src, 1'b0});
   wire vec_in = vec_a < `CCR_VEC_END;
   wire int_ok = go && op == OP_INT && src != 5'h00 &&
      src <= `CCR_SRC_MAX && vec_in && (nmi || (ie && !mask[src]));
   wire [15:0] tbl_a = `CCR_TBL_BASE + 16'({a8[4:0], 1'b0});
   wire [15:0] pair = {gpr[{a8[1:0], 1'b1}], gpr[{a8[1:0], 1'b0}]};

   // Arithmetic on the accumulator byte
   wire [7:0] acc_a = gpr[`CCR_R_A];
   wire [8:0] add9 = {1'b0, acc_a} + {1'b0, a8};
   wire [4:0] addn = {1'b0, acc_a[3:0]} + {1'b0, a8[3:0]};
   wire is_sub = op == OP_SUB;
   wire [7:0] res = is_sub ? acc_a - a8 : add9[7:0];
   wire cy_n = is_sub ? acc_a < a8 : add9[8];
   wire ac_n = is_sub ? acc_a[3:0] < a8[3:0] : addn[4];

   // Stack and vector byte paths
   wire [15:0] fa = st == ST_POP ? stack_top_pointer : vaddr;
   wire [7:0] fb = rd(fa);
   wire [7:0] pb = (cnt == 2'd2 || !vec_go) ? processor_flags_byte :
      cnt[0] ? instruction_pointer[15:8] : instruction_pointer[7:0];
   wire push = st == ST_PUSH;
   wire we = push || w_mdata;
   wire [15:0] wa = push ? stack_top_pointer - 16'd1 : maddr;
   wire [7:0] wd = push ? pb : hwdata[7:0];
   wire ccr_region_e wr_rg = region(wa);

   // Register read mux
   wire [7:0] ra = haddr[7:0];
   wire [31:0] rsel =
      ra == `CCR_A_STAT ? {27'h0, region(maddr), ie, !idle} :
      ra == `CCR_A_PC ? {16'h0, instruction_pointer} :
      ra == `CCR_A_PSW ? {24'h0, processor_flags_byte} :
      ra == `CCR_A_SP ? {16'h0, stack_top_pointer} :
      ra == `CCR_A_GLO ? {gpr[3], gpr[2], gpr[1], gpr[0]} :
      ra == `CCR_A_GHI ? {gpr[7], gpr[6], gpr[5], gpr[4]} :
      ra == `CCR_A_MASK ? mask :
      ra == `CCR_A_MADDR ? {16'h0, maddr} :
      ra == `CCR_A_MDATA ? {24'h0, rd(maddr)} : 32'h0;

   // Bus slave, zero wait, always OKAY
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_wr <= 1'b0;
         dp_a <= 8'h00;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dp_wr <= take && hwrite;
         dp_a <= ra;
         hrdata <= (take && !hwrite) ? rsel : 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Memory write port
   always_ff @(posedge clk) begin
      if (we && wr_rg == RG_HRAM)
         hram[wa[8:0]] <= wd;
      if (we && wr_rg == RG_DRAM)
         dram[wa[4:0]] <= wd;
   end

   // Vector store clears on reset so the first fetch is defined
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < VEC_BYTES; i++)
            vrom[i] <= 8'h00;
      end else if (we && wr_rg == RG_PROG && 32'(wa) < VEC_BYTES) begin
         vrom[wa[VA-1:0]] <= wd;
      end
   end

   // Stack pointer has no reset value
   always_ff @(posedge clk) begin
      if (push)
         stack_top_pointer <= stack_top_pointer - 16'd1;
      else if (st == ST_POP)
         stack_top_pointer <= stack_top_pointer + 16'd1;
      else if (w_sp)
         stack_top_pointer <= hwdata[15:0];
   end

   // Sequencer next state
   always_comb begin
      next_st = st;
      unique case (st)
         ST_IDLE: begin
            if (int_ok || (go && op == OP_SAVE))
               next_st = ST_PUSH;
            else if (go && (op == OP_RESTORE || op == OP_INTERRUPT_RETURN_INSTRUCTION))
               next_st = ST_POP;
            else if (go && (op == OP_RESET || op == OP_TABLE_CALL_INSTRUCTION))
               next_st = ST_VLO;
         end
         ST_PUSH:
            if (cnt == 2'd0)
               next_st = vec_go ? ST_VLO : ST_IDLE;
         ST_POP:
            if (cnt == 2'd0)
               next_st = ST_IDLE;
         ST_VLO: next_st = ST_VHI;
         ST_VHI: next_st = ST_IDLE;
      endcase
   end

   // Core state registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_VLO;
         busy <= 1'b1;
         vaddr <= `CCR_VEC_RESET;
         cnt <= 2'd0;
         vec_go <= 1'b0;
         processor_flags_byte <= `CCR_PSW_RST;
         instruction_pointer <= 16'h0000;
         mask <= `CCR_MASK_RST;
         maddr <= 16'h0000;
         for (int i = 0; i < 8; i++)
            gpr[i] <= 8'h00;
      end else begin
         st <= next_st;
         busy <= next_st != ST_IDLE;
         if (w_mask)
            mask <= hwdata;
         if (w_maddr)
            maddr <= hwdata[15:0];
         unique case (st)
            ST_IDLE: begin
               if (w_pc)
                  instruction_pointer <= hwdata[15:0];
               if (w_psw)
                  processor_flags_byte <= hwdata[7:0];
               if (w_glo)
                  for (int i = 0; i < 4; i++)
                     gpr[i] <= hwdata[8*i +: 8];
               if (w_ghi)
                  for (int i = 0; i < 4; i++)
                     gpr[i+4] <= hwdata[8*i +: 8];
               if (go) begin
                  case (op)
                     OP_RESET: begin
                        vaddr <= `CCR_VEC_RESET;
                        processor_flags_byte <= `CCR_PSW_RST;
                     end
                     OP_INT:
                        if (int_ok) begin
                           vaddr <= vec_a;
                           vec_go <= 1'b1;
                           cnt <= 2'd2;
                        end
                     OP_SAVE, OP_RESTORE:
                        cnt <= 2'd0;
                     OP_INTERRUPT_RETURN_INSTRUCTION:
                        cnt <= 2'd2;
                     OP_DI:
                        processor_flags_byte[`CCR_F_IE] <= 1'b0;
                     OP_EI:
                        processor_flags_byte[`CCR_F_IE] <= 1'b1;
                     OP_ADD, OP_SUB: begin
                        gpr[`CCR_R_A] <= res;
                        processor_flags_byte[`CCR_F_Z] <= res == 8'h00;
                        processor_flags_byte[`CCR_F_AC] <= ac_n;
                        processor_flags_byte[`CCR_F_CY] <= cy_n;
                     end
                     OP_ROR: begin
                        gpr[`CCR_R_A] <= {processor_flags_byte[`CCR_F_CY],
                           acc_a[7:1]};
                        processor_flags_byte[`CCR_F_CY] <= acc_a[0];
                     end
                     OP_BIT:
                        processor_flags_byte[`CCR_F_CY] <= acc_a[a8[2:0]];
                     OP_STEP:
                        instruction_pointer <= instruction_pointer +
                           16'(a8[2:0]);
                     OP_JMP:
                        instruction_pointer <= a16;
                     OP_JREG:
                        instruction_pointer <= pair;
                     OP_TABLE_CALL_INSTRUCTION:
                        vaddr <= tbl_a;
                     default: ;
                  endcase
               end
            end
            ST_PUSH:
               cnt <= cnt - 2'd1;
            ST_POP: begin
               cnt <= cnt - 2'd1;
               case (cnt)
                  2'd2: instruction_pointer[7:0] <= fb;
                  2'd1: instruction_pointer[15:8] <= fb;
                  default: processor_flags_byte <= fb;
               endcase
            end
            ST_VLO: begin
               instruction_pointer[7:0] <= fb;
               vaddr <= vaddr + 16'd1;
               if (vec_go)
                  processor_flags_byte[`CCR_F_IE] <= 1'b0;
            end
            ST_VHI: begin
               instruction_pointer[15:8] <= fb;
               vec_go <= 1'b0;
            end
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_psw_rst;
      $rose(rst_n) |-> processor_flags_byte == `CCR_PSW_RST && st == ST_VLO;
   endproperty
   a_psw_rst: assert property (p_psw_rst)
      else $error("flags byte not 02h after reset");

   sequence s_vec;
      st == ST_VLO ##1 st == ST_VHI;
   endsequence
   property p_vec;
      s_vec |=> instruction_pointer == {$past(fb), $past(fb, 2)};
   endproperty
   a_vec: assert property (p_vec)
      else $error("pointer not loaded from vector pair");

   property p_push;
      push |=> stack_top_pointer == $past(stack_top_pointer) - 16'd1;
   endproperty
   a_push: assert property (p_push)
      else $error("stack pointer not lowered on save");

   property p_pop;
      st == ST_POP |=> stack_top_pointer == $past(stack_top_pointer) + 16'd1;
   endproperty
   a_pop: assert property (p_pop)
      else $error("stack pointer not raised on restore");

   sequence s_take;
      int_ok ##1 push [*3];
   endsequence
   property p_take;
      s_take |=> st == ST_VLO ##1 !processor_flags_byte[`CCR_F_IE];
   endproperty
   a_take: assert property (p_take)
      else $error("enable not cleared on acknowledge");

   property p_refuse;
      go && op == OP_INT && !nmi && !ie |=> st == ST_IDLE;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("maskable request taken while disabled");

   property p_arith;
      go && (op == OP_ADD || op == OP_SUB) |=>
         processor_flags_byte[`CCR_F_Z] == (gpr[`CCR_R_A] == 8'h00) &&
         processor_flags_byte[`CCR_F_CY] == $past(cy_n);
   endproperty
   a_arith: assert property (p_arith)
      else $error("arithmetic flags wrong");

   property p_save1;
      go && op == OP_SAVE |=> push ##1 (idle &&
         stack_top_pointer == $past(stack_top_pointer, 2) - 16'd1);
   endproperty
   a_save1: assert property (p_save1)
      else $error("flags save did not move one byte");

   property p_step;
      go && op == OP_STEP |=> instruction_pointer ==
         $past(instruction_pointer) + (16'($past(a8)) & 16'h0007);
   endproperty
   a_step: assert property (p_step)
      else $error("pointer step wrong");

   property p_table_call_instruction;
      go && op == OP_TABLE_CALL_INSTRUCTION |=> st == ST_VLO && vaddr == $past(tbl_a);
   endproperty
   a_table_call_instruction: assert property (p_table_call_instruction)
      else $error("table call entry address wrong");

   property p_vec_range;
      vec_go && st == ST_VLO |-> vaddr <= `CCR_VEC_END;
   endproperty
   a_vec_range: assert property (p_vec_range)
      else $error("vector fetched outside vector table");
endmodule
`default_nettype wire

// ===== verilog/ccr_pkg.sv
// Types shared by the core state block.
// Assumes nothing of its surroundings.
package ccr_pkg;
   typedef enum {ST_IDLE, ST_PUSH, ST_POP, ST_VLO, ST_VHI} ccr_state_e;
   typedef enum logic [2:0] {RG_NONE, RG_PROG, RG_HRAM, RG_DRAM,
      RG_SFR} ccr_region_e;
   typedef enum logic [3:0] {OP_NOP = 4'h0, OP_RESET = 4'h1,
      OP_INT = 4'h2, OP_SAVE = 4'h3, OP_RESTORE = 4'h4, OP_INTERRUPT_RETURN_INSTRUCTION = 4'h5,
      OP_DI = 4'h6, OP_EI = 4'h7, OP_ADD = 4'h8, OP_SUB = 4'h9,
      OP_ROR = 4'ha, OP_BIT = 4'hb, OP_STEP = 4'hc, OP_JMP = 4'hd,
      OP_JREG = 4'he, OP_TABLE_CALL_INSTRUCTION = 4'hf} ccr_op_e;
endpackage

// ===== verilog/ccr_regs.svh
// Constants of the core state block: offsets, fields, resets, map.
// Assumes inclusion by ccr_core and the bench top module.
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH
`define CCR_A_CMD 8'h00
`define CCR_A_STAT 8'h04
`define CCR_A_PC 8'h08
`define CCR_A_PSW 8'h0c
`define CCR_A_SP 8'h10
`define CCR_A_GLO 8'h14
`define CCR_A_GHI 8'h18
`define CCR_A_MASK 8'h1c
`define CCR_A_MADDR 8'h20
`define CCR_A_MDATA 8'h24
`define CCR_VEC_RESET 16'h0000
`define CCR_VEC_END 16'h0023
`define CCR_VEC_BASE 16'h0002
`define CCR_TBL_BASE 16'h0040
`define CCR_TBL_END 16'h007f
`define CCR_ROM_BYTES 12288
`define CCR_VEC_BYTES 128
`define CCR_HRAM_LO 16'hfd00
`define CCR_HRAM_HI 16'hfeff
`define CCR_DRAM_LO 16'hfa00
`define CCR_DRAM_HI 16'hfa1b
`define CCR_DRAM_N 28
`define CCR_SFR_LO 16'hff00
`define CCR_UNMAPPED 8'hff
`define CCR_PSW_RST 8'h02
`define CCR_MASK_RST 32'hffffffff
`define CCR_F_IE 7
`define CCR_F_Z 6
`define CCR_F_AC 4
`define CCR_F_CY 0
`define CCR_R_A 1
`define CCR_NMI_SRC 5'h01
`define CCR_SRC_MAX 5'h10
`endif
